//--- dpac_checker.sv
// access-control checker and routing verdict for one downstream port, with apb registers
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "dpac_defines.svh"

module dpac_checker #(
  parameter logic [1:0] PORT_KIND   = `DPAC_KIND_SWITCH, // function kind of this port
  parameter logic [2:0] PORT_ID     = 3'h0,              // index of this port among peers
  parameter logic       EGRESS_IMPL = 1'b1               // egress control present
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   pkt_valid,
  input  wire dpac_pkg::dpac_pkt_t    pkt,
  output logic                        verdict_valid,
  output dpac_pkg::dpac_verdict_t     verdict,
  output logic                        viol_pulse
);

  // ---------------------------------------------------------------- state
  logic [`DPAC_CTRL_W-1:0] ctrl_r;       // enables v,b,r,c,u,e,t
  logic [7:0]              egress_r;     // one block bit per peer egress port
  logic [7:0]              sec_bus_r;    // lower end of the bus aperture
  logic [7:0]              sub_bus_r;    // upper end of the bus aperture
  logic [15:0]             viol_cnt_r;   // saturating violation count
  logic [3:0]              last_cause_r; // cause of the latest violation
  logic                    pready_r;     // apb ready, one wait state
  logic [31:0]             prdata_r;     // apb read data
  logic                    pslverr_r;    // apb error on unmapped address
  logic                    vvalid_r;     // verdict strobe
  dpac_pkg::dpac_verdict_t verdict_r;    // verdict held until the next packet
  logic                    viol_r;       // violation strobe
  logic                    ctrl_wr_seen; // helper: a control write has happened

  // ---------------------------------------------------------------- decode
  logic       acc_go;     // access phase completing this cycle
  logic       wr_go;      // write taking effect
  logic       mapped;     // address hits a register
  logic       is_switch;  // switch downstream port
  logic       acs_on;     // this function carries the capability
  logic [6:0] cap_bits;   // implemented controls

  assign is_switch = (PORT_KIND == `DPAC_KIND_SWITCH);
  // bridges and event collectors have no capability at all
  assign acs_on    = (PORT_KIND == `DPAC_KIND_SWITCH) || (PORT_KIND == `DPAC_KIND_ROOT);
  // v and b always; the peer controls are built for both kinds as well
  assign cap_bits  = acs_on ? {1'b1, EGRESS_IMPL, 5'h1f} : 7'h00;
  assign acc_go    = ce && psel && penable && pready_r;
  assign wr_go     = acc_go && pwrite && mapped;
  assign mapped    = (paddr == `DPAC_OFF_CTRL)   || (paddr == `DPAC_OFF_EGRESS) ||
                     (paddr == `DPAC_OFF_BUSNUM) || (paddr == `DPAC_OFF_STATUS) ||
                     (paddr == `DPAC_OFF_CAP);

  // ---------------------------------------------------------------- enables
  logic en_v, en_b, en_r, en_c, en_u, en_e, en_t;
  assign en_v = ctrl_r[`DPAC_CTRL_V];
  assign en_b = ctrl_r[`DPAC_CTRL_B];
  assign en_r = ctrl_r[`DPAC_CTRL_R];
  assign en_c = ctrl_r[`DPAC_CTRL_C];
  assign en_u = ctrl_r[`DPAC_CTRL_U];
  assign en_e = ctrl_r[`DPAC_CTRL_E];
  assign en_t = ctrl_r[`DPAC_CTRL_T];

  // apb ready: one wait state, then ready for a single cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else if (ce) begin
      pready_r <= psel && penable && !pready_r;
    end
  end

  // read data and error, loaded in the same cycle as ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready_r) begin
        pslverr_r <= !mapped;
        unique case (paddr)
          `DPAC_OFF_CTRL:   prdata_r <= {25'h0, ctrl_r};
          `DPAC_OFF_EGRESS: prdata_r <= {24'h0, egress_r};
          `DPAC_OFF_BUSNUM: prdata_r <= {16'h0, sub_bus_r, sec_bus_r};
          `DPAC_OFF_STATUS: prdata_r <= {12'h0, last_cause_r, viol_cnt_r};
          `DPAC_OFF_CAP:    prdata_r <= {25'h0, cap_bits};
          default:          prdata_r <= 32'h0; // unmapped reads as zero
        endcase
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // control register: reset leaves every check off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `DPAC_CTRL_RST;
    end else if (wr_go && (paddr == `DPAC_OFF_CTRL)) begin
      // unimplemented controls stay zero
      ctrl_r <= pwdata[`DPAC_CTRL_W-1:0] & cap_bits;
    end
  end

  // egress vector, one bit per target port, only when egress control is built
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      egress_r <= `DPAC_EGRESS_RST;
    end else if (wr_go && (paddr == `DPAC_OFF_EGRESS) && EGRESS_IMPL) begin
      egress_r <= pwdata[7:0];
    end
  end

  // bus aperture bounds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_bus_r <= `DPAC_BUS_RST;
      sub_bus_r <= `DPAC_BUS_RST;
    end else if (wr_go && (paddr == `DPAC_OFF_BUSNUM)) begin
      sec_bus_r <= pwdata[`DPAC_SEC_LSB +: 8];
      sub_bus_r <= pwdata[`DPAC_SUB_LSB +: 8];
    end
  end

  // ---------------------------------------------------------------- verdict
  logic                    srcval_bad;  // requester outside the aperture
  logic                    xlate_bad;   // non-default address type
  logic                    xlated_mem;  // translated memory request
  logic                    egress_hit;  // vector bit of the target port
  dpac_pkg::dpac_dec_t     dec_nxt;
  dpac_pkg::dpac_cause_t   cause_nxt;

  // completions are exempt from source validation
  assign srcval_bad = en_v && !pkt.is_cpl &&
                      ((pkt.req_bus < sec_bus_r) || (pkt.req_bus > sub_bus_r));
  // completions are exempt from translation blocking
  assign xlate_bad  = en_b && !pkt.is_cpl && pkt.is_mem &&
                      (pkt.at != `DPAC_AT_DEFAULT);
  assign xlated_mem = pkt.is_mem && (pkt.at == `DPAC_AT_XLATED);
  assign egress_hit = egress_r[pkt.tgt_port];

  // routing decision; order of the branches is the priority
  always_comb begin
    dec_nxt   = dpac_pkg::DPAC_ROUTE;
    cause_nxt = dpac_pkg::DPAC_CAUSE_NONE;
    if (!acs_on || !pkt.upstream) begin
      // no capability, or travelling downstream: untouched
      dec_nxt = dpac_pkg::DPAC_ROUTE;
    end else if (srcval_bad) begin
      // applies to multicast too
      dec_nxt   = dpac_pkg::DPAC_BLOCK;
      cause_nxt = dpac_pkg::DPAC_CAUSE_SRCVAL;
    end else if (pkt.multicast) begin
      // every other control leaves multicast alone
      dec_nxt = dpac_pkg::DPAC_ROUTE;
    end else if (xlate_bad) begin
      // ahead of forwarding and all peer controls
      dec_nxt   = dpac_pkg::DPAC_BLOCK;
      cause_nxt = dpac_pkg::DPAC_CAUSE_XLATE;
    end else if (pkt.self_tgt && en_u) begin
      // self-targeted: switch forwards up, root treats as redirected
      if (is_switch) begin
        dec_nxt = dpac_pkg::DPAC_UPSTREAM;
      end else if (pkt.is_cpl) begin
        dec_nxt = dpac_pkg::DPAC_ORDERED;
      end else begin
        dec_nxt = dpac_pkg::DPAC_VALIDATE;
      end
    end else if (pkt.is_cpl) begin
      // only completion redirect looks at completions
      if (pkt.p2p && en_c && !pkt.relaxed) begin
        dec_nxt = is_switch ? dpac_pkg::DPAC_UPSTREAM : dpac_pkg::DPAC_ORDERED;
      end else begin
        dec_nxt = dpac_pkg::DPAC_ROUTE;
      end
    end else if (pkt.p2p) begin
      // requests: completion redirect plays no part here
      if (en_t && xlated_mem) begin
        dec_nxt = dpac_pkg::DPAC_ROUTE;
      end else if (en_r) begin
        // redirect wins over egress when both are on
        dec_nxt = is_switch ? dpac_pkg::DPAC_UPSTREAM : dpac_pkg::DPAC_VALIDATE;
      end else if (en_e && egress_hit) begin
        // decided by this ingress port, which also reports it
        dec_nxt   = dpac_pkg::DPAC_BLOCK;
        cause_nxt = dpac_pkg::DPAC_CAUSE_EGRESS;
      end else begin
        dec_nxt = dpac_pkg::DPAC_ROUTE;
      end
    end
  end

  // verdict register, one result per accepted packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vvalid_r  <= 1'b0;
      verdict_r <= '{dec: dpac_pkg::DPAC_ROUTE, cause: dpac_pkg::DPAC_CAUSE_NONE, port: 3'h0};
    end else if (ce) begin
      vvalid_r <= pkt_valid;
      if (pkt_valid) begin
        verdict_r.dec   <= dec_nxt;
        verdict_r.cause <= cause_nxt;
        verdict_r.port  <= PORT_ID; // charged to the receiving port
      end
    end
  end

  // violation strobe, one enabled cycle per blocked packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_r <= 1'b0;
    end else if (ce) begin
      viol_r <= pkt_valid && (dec_nxt == dpac_pkg::DPAC_BLOCK);
    end
  end

  // violation count and last cause; a new violation beats a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_cnt_r   <= 16'h0;
      last_cause_r <= 4'h0;
    end else if (ce) begin
      if (pkt_valid && (dec_nxt == dpac_pkg::DPAC_BLOCK)) begin
        last_cause_r <= cause_nxt;
        if (wr_go && (paddr == `DPAC_OFF_STATUS)) begin
          viol_cnt_r <= 16'h1;
        end else if (viol_cnt_r != 16'hffff) begin
          viol_cnt_r <= viol_cnt_r + 16'h1;
        end
      end else if (wr_go && (paddr == `DPAC_OFF_STATUS)) begin
        viol_cnt_r   <= 16'h0;
        last_cause_r <= 4'h0;
      end
    end
  end

  // helper: remembers the first control write, read only by an assertion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_wr_seen <= 1'b0;
    end else if (wr_go && (paddr == `DPAC_OFF_CTRL)) begin
      ctrl_wr_seen <= 1'b1;
    end
  end

  assign pready        = pready_r;
  assign prdata        = prdata_r;
  assign pslverr       = pslverr_r;
  assign verdict_valid = vvalid_r;
  assign verdict       = verdict_r;
  assign viol_pulse    = viol_r;

  // ---------------------------------------------------------------- checks
  a_reset_all_off: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_wr_seen |-> (ctrl_r == 7'h00))
    else $error("control enabled without a software write");

  a_mcast_passes: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && acs_on && pkt.upstream && pkt.multicast && !srcval_bad)
    |=> (verdict_r.dec == dpac_pkg::DPAC_ROUTE))
    else $error("multicast altered by a control other than source validation");

  a_srcval_block: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && acs_on && pkt.upstream && en_v && !pkt.is_cpl &&
     (pkt.req_bus > sub_bus_r))
    |=> (verdict_r.dec == dpac_pkg::DPAC_BLOCK) && (verdict_r.cause == dpac_pkg::DPAC_CAUSE_SRCVAL))
    else $error("out of aperture requester not blocked");

  a_xlate_first: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && acs_on && pkt.upstream && !pkt.multicast && !srcval_bad && xlate_bad)
    |=> (verdict_r.cause == dpac_pkg::DPAC_CAUSE_XLATE))
    else $error("translation violation lost priority");

  a_down_untouched: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && !pkt.upstream) |=> (verdict_r.dec == dpac_pkg::DPAC_ROUTE))
    else $error("downstream packet was redirected or blocked");

  a_cpl_redirect: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && is_switch && pkt.upstream && pkt.is_cpl && pkt.p2p && !pkt.multicast &&
     !pkt.self_tgt && en_c && !pkt.relaxed)
    |=> (verdict_r.dec == dpac_pkg::DPAC_UPSTREAM))
    else $error("non relaxed peer completion not redirected");

  a_req_redirect: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && acs_on && pkt.upstream && !pkt.is_cpl && pkt.p2p && !pkt.multicast &&
     !pkt.self_tgt && !srcval_bad && !xlate_bad && en_r && !(en_t && xlated_mem))
    |=> (verdict_r.dec == (is_switch ? dpac_pkg::DPAC_UPSTREAM : dpac_pkg::DPAC_VALIDATE)))
    else $error("peer request not redirected");

  a_egress_cpl: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && pkt.is_cpl) |=> (verdict_r.cause != dpac_pkg::DPAC_CAUSE_EGRESS))
    else $error("completion blocked by egress control");

  a_viol_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && viol_r) |-> (verdict_r.dec == dpac_pkg::DPAC_BLOCK) && vvalid_r &&
                        (verdict_r.port == PORT_ID) ##1 (!ce || !viol_r || $past(pkt_valid)))
    else $error("violation pulse without a blocked verdict");

  a_cpl_exempt: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && pkt.is_cpl)
    |=> (verdict_r.cause != dpac_pkg::DPAC_CAUSE_SRCVAL) &&
        (verdict_r.cause != dpac_pkg::DPAC_CAUSE_XLATE))
    else $error("completion charged by a request check");

  a_xlate_block: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && acs_on && pkt.upstream && en_b && !pkt.is_cpl && pkt.is_mem &&
     (pkt.at != `DPAC_AT_DEFAULT) && !pkt.multicast && !srcval_bad)
    |=> (verdict_r.dec == dpac_pkg::DPAC_BLOCK))
    else $error("non default address type not blocked");

  a_root_ordered: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && acs_on && !is_switch && pkt.upstream && pkt.is_cpl && pkt.p2p &&
     !pkt.multicast && !pkt.self_tgt && en_c && !pkt.relaxed)
    |=> (verdict_r.dec == dpac_pkg::DPAC_ORDERED))
    else $error("root port completion not ordered");

  a_self_forward: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && acs_on && pkt.upstream && pkt.self_tgt && en_u && !pkt.multicast &&
     !srcval_bad && !xlate_bad)
    |=> (verdict_r.dec == (is_switch ? dpac_pkg::DPAC_UPSTREAM :
                           $past(pkt.is_cpl) ? dpac_pkg::DPAC_ORDERED :
                                               dpac_pkg::DPAC_VALIDATE)))
    else $error("self targeted packet not sent up");

  a_egress_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && acs_on && pkt.upstream && !pkt.is_cpl && pkt.p2p && !pkt.multicast &&
     !pkt.self_tgt && !srcval_bad && !xlate_bad && !en_r && !(en_t && xlated_mem) && en_e)
    |=> ((verdict_r.dec == dpac_pkg::DPAC_BLOCK) == $past(egress_hit)))
    else $error("egress vector bit not honoured");

  a_direct_xlated: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && acs_on && pkt.upstream && !pkt.is_cpl && pkt.p2p && !pkt.multicast &&
     !pkt.self_tgt && !srcval_bad && !xlate_bad && en_t && xlated_mem)
    |=> (verdict_r.dec == dpac_pkg::DPAC_ROUTE))
    else $error("translated peer request not routed directly");

  a_no_capability: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pkt_valid && !acs_on)
    |=> (verdict_r.dec == dpac_pkg::DPAC_ROUTE) && (ctrl_r == 7'h00))
    else $error("function without the capability acted on a packet");

  // a low enable must hold every register, the bus handshake included
  a_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(ctrl_r) && $stable(verdict_r) && $stable(viol_cnt_r) && $stable(pready_r))
    else $error("state moved while the clock enable was low");

endmodule : dpac_checker

//--- dpac_defines.svh
// register offsets, field positions, reset values and encodings of the access-control checker
`ifndef DPAC_DEFINES_SVH
`define DPAC_DEFINES_SVH
`define DPAC_OFF_CTRL      12'h000
`define DPAC_OFF_EGRESS    12'h004
`define DPAC_OFF_BUSNUM    12'h008
`define DPAC_OFF_STATUS    12'h00c
`define DPAC_OFF_CAP       12'h010
`define DPAC_CTRL_V        0
`define DPAC_CTRL_B        1
`define DPAC_CTRL_R        2
`define DPAC_CTRL_C        3
`define DPAC_CTRL_U        4
`define DPAC_CTRL_E        5
`define DPAC_CTRL_T        6
`define DPAC_CTRL_W        7
`define DPAC_CTRL_RST      7'h00
`define DPAC_EGRESS_RST    8'h00
`define DPAC_BUS_RST       8'h00
`define DPAC_SEC_LSB       0
`define DPAC_SUB_LSB       8
`define DPAC_STAT_CAUSE_LSB 16
`define DPAC_AT_DEFAULT    2'h0
`define DPAC_AT_XLATED     2'h2
`define DPAC_KIND_SWITCH   2'h0
`define DPAC_KIND_ROOT     2'h1
`define DPAC_KIND_BRIDGE   2'h2
`define DPAC_KIND_EVTCOL   2'h3
`endif

//--- dpac_pkg.sv
// types shared by the access-control checker and its surroundings
package dpac_pkg;
  // routing verdict, one-hot
  typedef enum logic [4:0] {
    DPAC_ROUTE    = 5'h01, // normal routing
    DPAC_BLOCK    = 5'h02, // dropped as an access violation
    DPAC_UPSTREAM = 5'h04, // sent upstream toward the root complex
    DPAC_VALIDATE = 5'h08, // handed to the root complex request validation
    DPAC_ORDERED  = 5'h10  // completion held behind validated requests, then sent down
  } dpac_dec_t;
  // cause attached to a blocked packet, one-hot
  typedef enum logic [3:0] {
    DPAC_CAUSE_NONE   = 4'h0,
    DPAC_CAUSE_SRCVAL = 4'h1,
    DPAC_CAUSE_XLATE  = 4'h2,
    DPAC_CAUSE_EGRESS = 4'h4
  } dpac_cause_t;
  // one packet header as seen at the ingress
  typedef struct packed {
    logic       upstream;   // travelling upstream
    logic       is_cpl;     // completion, else request
    logic       is_mem;     // memory request
    logic       multicast;  // multicast packet
    logic       p2p;        // target is a peer port
    logic       self_tgt;   // target is this port's own egress
    logic [2:0] tgt_port;   // peer egress port index
    logic [7:0] req_bus;    // bus number of the requester id
    logic [1:0] at;         // address-type field
    logic       relaxed;    // relaxed-ordering attribute
  } dpac_pkt_t;
  // verdict as handed on
  typedef struct packed {
    dpac_dec_t   dec;
    dpac_cause_t cause;
    logic [2:0]  port;      // receiving port charged with a violation
  } dpac_verdict_t;
endpackage : dpac_pkg

//--- dpac_pkt_source.sv
// packet source standing in for the peer that feeds the port ingress
`timescale 1ns/1ns
module dpac_pkt_source (
  input  wire logic           pclk,
  output logic                pkt_valid,
  output dpac_pkg::dpac_pkt_t pkt
);
  // quiet until the first header
  initial begin
    pkt_valid = 1'b0;
    pkt       = '0;
  end
  // one header per call, after gap idle cycles; valid stands one edge
  task automatic send(input dpac_pkg::dpac_pkt_t p, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    pkt_valid <= 1'b1;
    pkt       <= p;
    @(posedge pclk);
    pkt_valid <= 1'b0;
    // idle header is the inverse of the last, so stale fields never pass for a match
    pkt       <= ~p;
  endtask : send
endmodule : dpac_pkt_source

//--- downstream_port_p2p_access_control_test.sv
// self-checking bench for the access-control checker, switch downstream port
`timescale 1ns/1ns
`include "dpac_defines.svh"
module downstream_port_p2p_access_control_test;
  localparam logic [2:0]           PID = 3'h5;     // index of the port under test
  localparam dpac_pkg::dpac_dec_t  RT  = dpac_pkg::DPAC_ROUTE;
  localparam dpac_pkg::dpac_dec_t  BK  = dpac_pkg::DPAC_BLOCK;
  localparam dpac_pkg::dpac_dec_t  UP  = dpac_pkg::DPAC_UPSTREAM;
  localparam dpac_pkg::dpac_dec_t  VA  = dpac_pkg::DPAC_VALIDATE;
  localparam dpac_pkg::dpac_dec_t  OD  = dpac_pkg::DPAC_ORDERED;
  localparam dpac_pkg::dpac_cause_t C0 = dpac_pkg::DPAC_CAUSE_NONE;
  localparam dpac_pkg::dpac_cause_t CS = dpac_pkg::DPAC_CAUSE_SRCVAL;
  localparam dpac_pkg::dpac_cause_t CX = dpac_pkg::DPAC_CAUSE_XLATE;
  localparam dpac_pkg::dpac_cause_t CE = dpac_pkg::DPAC_CAUSE_EGRESS;
  // header flags {upstream, cpl, mem, multicast, p2p, self}
  localparam logic [5:0] UREQ = 6'h28, UCPL = 6'h30, MC = 6'h04, P2P = 6'h02, SELF = 6'h01;
  logic                    pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic                    pkt_valid, verdict_valid, viol_pulse, err;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, q, prdata_br;
  dpac_pkg::dpac_pkt_t     pkt;
  dpac_pkg::dpac_verdict_t verdict, verdict_rt, verdict_br;
  int                      miscompares, comparisons, nviol;

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  dpac_checker #(.PORT_KIND(`DPAC_KIND_SWITCH), .PORT_ID(PID), .EGRESS_IMPL(1'b1)) u_dpac_checker (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt(pkt),
    .verdict_valid(verdict_valid), .verdict(verdict), .viol_pulse(viol_pulse));
  dpac_pkt_source u_dpac_pkt_source (.pclk(pclk), .pkt_valid(pkt_valid), .pkt(pkt));
  // root port and bridge copies see the same bus and packets; only a few outputs are compared
  dpac_checker #(.PORT_KIND(`DPAC_KIND_ROOT), .PORT_ID(PID)) u_dpac_checker_rt (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(), .pslverr(),
    .pkt_valid(pkt_valid), .pkt(pkt), .verdict_valid(), .verdict(verdict_rt), .viol_pulse());
  dpac_checker #(.PORT_KIND(`DPAC_KIND_BRIDGE), .PORT_ID(PID)) u_dpac_checker_br (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(prdata_br), .pslverr(),
    .pkt_valid(pkt_valid), .pkt(pkt), .verdict_valid(), .verdict(verdict_br), .viol_pulse());

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // one compare; four-state so an unknown never matches
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      stop_test();
    end
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask : rdchk
  function automatic dpac_pkg::dpac_pkt_t mk(input logic [5:0] f, input logic [2:0] t,
                                             input logic [7:0] b, input logic [1:0] at,
                                             input logic rel);
    mk = {f, t, b, at, rel};
  endfunction : mk
  // send one header, then look at the verdict in the cycle it stands
  task automatic pchk(input dpac_pkg::dpac_pkt_t p, input dpac_pkg::dpac_dec_t d,
                      input dpac_pkg::dpac_cause_t c);
    u_dpac_pkt_source.send(p, 0);
    #1;
    check("decision", {23'h0, verdict.dec, verdict.cause}, {23'h0, d, c});
    check("verdict valid", {31'h0, verdict_valid}, 32'h1);
    check("violation", {31'h0, viol_pulse}, {31'h0, d == BK});
    if (d == BK) begin
      check("port", {29'h0, verdict.port}, {29'h0, PID});
      nviol++;
    end
  endtask : pchk

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    rdchk("ctrl", `DPAC_OFF_CTRL, 32'h0);
    rdchk("cap", `DPAC_OFF_CAP, 32'h7f);
    check("bridge cap", prdata_br, 32'h0);
    pchk(mk(UREQ | P2P, 3'h3, 8'h99, 2'h1, 1'b0), RT, C0);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", q, 32'h0);
    $display("test reset done");
    // source validation window 0x10..0x20
    apb(1'b1, `DPAC_OFF_BUSNUM, 32'h2010);
    apb(1'b1, `DPAC_OFF_CTRL, 32'h1 << `DPAC_CTRL_V);
    pchk(mk(UREQ, 3'h0, 8'h0f, 2'h0, 1'b0), BK, CS);
    check("bridge decision", {27'h0, verdict_br.dec}, {27'h0, RT});
    pchk(mk(UREQ, 3'h0, 8'h10, 2'h0, 1'b0), RT, C0);
    pchk(mk(UREQ, 3'h0, 8'h20, 2'h0, 1'b0), RT, C0);
    pchk(mk(UCPL, 3'h0, 8'h05, 2'h0, 1'b0), RT, C0);
    pchk(mk(UREQ | MC, 3'h0, 8'h21, 2'h0, 1'b0), BK, CS);
    @(posedge pclk);
    #1;
    check("pulse width", {31'h0, viol_pulse}, 32'h0);
    $display("test source validation done");
    // translation blocking with upstream forwarding
    apb(1'b1, `DPAC_OFF_CTRL, (32'h1 << `DPAC_CTRL_B) | (32'h1 << `DPAC_CTRL_U));
    pchk(mk(UREQ | SELF, 3'h0, 8'h00, 2'h1, 1'b0), BK, CX);
    pchk(mk(UCPL | SELF, 3'h0, 8'h00, 2'h1, 1'b0), UP, C0);
    check("root decision", {27'h0, verdict_rt.dec}, {27'h0, OD});
    pchk(mk(UREQ | SELF, 3'h0, 8'h00, 2'h0, 1'b0), UP, C0);
    check("root decision", {27'h0, verdict_rt.dec}, {27'h0, VA});
    pchk(mk(UREQ | MC | P2P, 3'h1, 8'h00, 2'h1, 1'b0), RT, C0);
    $display("test translation done");
    // request and completion redirect
    apb(1'b1, `DPAC_OFF_CTRL, (32'h1 << `DPAC_CTRL_R) | (32'h1 << `DPAC_CTRL_C));
    pchk(mk(UREQ | P2P, 3'h2, 8'h00, 2'h0, 1'b0), UP, C0);
    check("root decision", {27'h0, verdict_rt.dec}, {27'h0, VA});
    pchk(mk(6'h0a, 3'h2, 8'h00, 2'h0, 1'b0), RT, C0);
    pchk(mk(UCPL | P2P, 3'h2, 8'h00, 2'h0, 1'b0), UP, C0);
    check("root decision", {27'h0, verdict_rt.dec}, {27'h0, OD});
    pchk(mk(UCPL | P2P, 3'h2, 8'h00, 2'h0, 1'b1), RT, C0);
    pchk(mk(6'h12, 3'h2, 8'h00, 2'h0, 1'b0), RT, C0);
    apb(1'b1, `DPAC_OFF_CTRL, 32'h1 << `DPAC_CTRL_C);
    pchk(mk(UREQ | P2P, 3'h2, 8'h00, 2'h0, 1'b0), RT, C0);
    $display("test redirect done");
    // egress vector blocks port 3 only, direct translated on
    apb(1'b1, `DPAC_OFF_EGRESS, 32'h08);
    apb(1'b1, `DPAC_OFF_CTRL, (32'h1 << `DPAC_CTRL_E) | (32'h1 << `DPAC_CTRL_T));
    pchk(mk(UREQ | P2P, 3'h3, 8'h00, 2'h0, 1'b0), BK, CE);
    pchk(mk(UREQ | P2P, 3'h2, 8'h00, 2'h0, 1'b0), RT, C0);
    pchk(mk(UCPL | P2P, 3'h3, 8'h00, 2'h2, 1'b0), RT, C0);
    pchk(mk(UREQ | P2P, 3'h3, 8'h00, 2'h2, 1'b0), RT, C0);
    pchk(mk(6'h22, 3'h3, 8'h00, 2'h2, 1'b0), BK, CE);
    apb(1'b1, `DPAC_OFF_CTRL, (32'h1 << `DPAC_CTRL_R) | (32'h1 << `DPAC_CTRL_T));
    pchk(mk(UREQ | P2P, 3'h3, 8'h00, 2'h2, 1'b0), RT, C0);
    pchk(mk(6'h22, 3'h3, 8'h00, 2'h2, 1'b0), UP, C0);
    // with the enable low a header goes unseen and the last verdict stays
    @(posedge pclk);
    ce <= 1'b0;
    u_dpac_pkt_source.send(mk(UREQ | P2P, 3'h2, 8'h00, 2'h0, 1'b0), 0);
    #1;
    check("frozen valid", {31'h0, verdict_valid}, 32'h0);
    check("frozen decision", {27'h0, verdict.dec}, {27'h0, UP});
    @(posedge pclk);
    ce <= 1'b1;
    $display("test egress done");
    // status counts every block and keeps the last cause
    rdchk("status", `DPAC_OFF_STATUS, {12'h0, 4'h4, 16'(nviol)});
    apb(1'b1, `DPAC_OFF_STATUS, 32'h0);
    apb(1'b0, `DPAC_OFF_STATUS, 32'h0);
    check("status count", {16'h0, q[15:0]}, 32'h0);
    apb(1'b1, `DPAC_OFF_CAP, 32'h0);
    rdchk("cap", `DPAC_OFF_CAP, 32'h7f);
    apb(1'b1, `DPAC_OFF_CTRL, 32'h7f);
    rdchk("ctrl", `DPAC_OFF_CTRL, 32'h7f);
    $display("test status done");
    stop_test();
  end
endmodule : downstream_port_p2p_access_control_test
